// ### core/dcm_consts.svh
// Offsets, field positions and reset values of the comparator C match registers
`ifndef DCM_CONSTS_SVH
`define DCM_CONSTS_SVH
`define DCM_ADDR_W 16
`define DCM_OFF_CTL 16'h0130
`define DCM_OFF_ADDR_HI 16'h0135
`define DCM_OFF_ADDR_MID 16'h0136
`define DCM_OFF_ADDR_LO 16'h0137
`define DCM_OFF_DATA 16'h0138
`define DCM_OFF_DATA_END 16'h013B
`define DCM_OFF_MASK 16'h013C
`define DCM_OFF_MASK_END 16'h013F
`define DCM_BIT_NDB 6
`define DCM_BIT_INST 5
`define DCM_BIT_RW 3
`define DCM_BIT_RWE 2
`define DCM_BIT_COMPE 0
`define DCM_CTL_WMASK 8'h6D
`define DCM_RST_CTL 8'h00
`define DCM_RST_ADDR 24'h000000
`define DCM_RST_DATA 32'h00000000
`define DCM_RST_MASK 32'h00000000
`endif

// ### core/dcm_pkg.sv
// Types shared by the comparator C match register block
package dcm_pkg;
  // One monitored bus access
  typedef struct packed {
    logic valid;
    logic inst;
    logic read;
    logic cop;
    logic [23:0] addr;
    logic [31:0] data;
  } dcm_access_t;
  // Software visible configuration
  typedef struct packed {
    logic [7:0] ctl;
    logic [23:0] addr;
    logic [31:0] data;
    logic [31:0] mask;
  } dcm_regs_t;
endpackage

// ### core/dcm_match_regs.sv
// Comparator C match registers and the address/data match logic
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`include "dcm_consts.svh"

module dcm_match_regs
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [`DCM_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic unit_armed,
  input wire logic trace_in_progress_flag,
  input wire dcm_pkg::dcm_access_t mon,
  output logic comp_match
);

  // Masked equality of bus data against the compare value
  function automatic logic data_equal(
    input logic [31:0] bus,
    input logic [31:0] value,
    input logic [31:0] mask
  );
    data_equal = ((bus ^ value) & mask) == 32'h00000000;
  endfunction

  // Byte lane k of a word, k=0 being bits 31..24
  function automatic logic [7:0] get_byte(
    input logic [31:0] word,
    input logic [1:0] k
  );
    get_byte = word[(5'd24 - {k, 3'b000}) +: 8];
  endfunction

  // Word with lane k replaced by b
  function automatic logic [31:0] put_byte(
    input logic [31:0] word,
    input logic [1:0] k,
    input logic [7:0] b
  );
    logic [31:0] w;
    w = word;
    w[(5'd24 - {k, 3'b000}) +: 8] = b;
    put_byte = w;
  endfunction

  dcm_pkg::dcm_regs_t regs_reg;
  dcm_pkg::dcm_regs_t regs_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic match_reg;
  logic match_next;
  logic wr_ok;
  logic in_data;
  logic in_mask;
  logic addr_hit;
  logic data_hit;
  logic rw_hit;
  logic [31:0] eff_mask;

  assign reg_rdata = rdata_reg;
  assign comp_match = match_reg;

  // Write permission and lane decode
  assign wr_ok = reg_wr && !unit_armed && !trace_in_progress_flag;
  assign in_data = reg_addr >= `DCM_OFF_DATA && reg_addr <= `DCM_OFF_DATA_END;
  assign in_mask = reg_addr >= `DCM_OFF_MASK && reg_addr <= `DCM_OFF_MASK_END;

  // Next register contents
  always_comb
  begin
    regs_next = regs_reg;
    if (wr_ok)
    begin
      if (in_data)
        regs_next.data = put_byte(regs_reg.data, reg_addr[1:0], reg_wdata);
      else if (in_mask)
        regs_next.mask = put_byte(regs_reg.mask, reg_addr[1:0], reg_wdata);
      else
      begin
        unique case (reg_addr)
          `DCM_OFF_CTL: regs_next.ctl = reg_wdata & `DCM_CTL_WMASK;
          `DCM_OFF_ADDR_HI: regs_next.addr[23:16] = reg_wdata;
          `DCM_OFF_ADDR_MID: regs_next.addr[15:8] = reg_wdata;
          `DCM_OFF_ADDR_LO: regs_next.addr[7:0] = reg_wdata;
          default: regs_next = regs_reg;
        endcase
      end
    end
  end

  // Register storage
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      regs_reg.ctl <= `DCM_RST_CTL;
      regs_reg.addr <= `DCM_RST_ADDR;
      regs_reg.data <= `DCM_RST_DATA;
      regs_reg.mask <= `DCM_RST_MASK;
    end
    else
      regs_reg <= regs_next;
  end

  // Read data, valid only in the cycle after the strobe
  always_comb
  begin
    rdata_next = 8'h00;
    if (reg_rd)
    begin
      if (in_data)
        rdata_next = get_byte(regs_reg.data, reg_addr[1:0]);
      else if (in_mask)
        rdata_next = get_byte(regs_reg.mask, reg_addr[1:0]);
      else
      begin
        unique case (reg_addr)
          `DCM_OFF_CTL: rdata_next = regs_reg.ctl;
          `DCM_OFF_ADDR_HI: rdata_next = regs_reg.addr[23:16];
          `DCM_OFF_ADDR_MID: rdata_next = regs_reg.addr[15:8];
          `DCM_OFF_ADDR_LO: rdata_next = regs_reg.addr[7:0];
          default: rdata_next = 8'h00;
        endcase
      end
    end
  end

  // Read data register
  always_ff @(posedge mclk)
  begin
    if (reset)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= rdata_next;
  end

  // Address, data and direction qualification
  assign addr_hit = mon.addr == regs_reg.addr;
  assign eff_mask = mon.cop ? {16'h0000, regs_reg.mask[15:0]} : regs_reg.mask;
  assign rw_hit = !regs_reg.ctl[`DCM_BIT_RWE] || (mon.read == regs_reg.ctl[`DCM_BIT_RW]);

  // Equal or differing data per the invert bit
  always_comb
  begin
    data_hit = data_equal(mon.data, regs_reg.data, eff_mask);
    if (regs_reg.ctl[`DCM_BIT_NDB])
      data_hit = !data_hit;
  end

  // Match decision
  always_comb
  begin
    match_next = 1'b0;
    if (mon.valid && regs_reg.ctl[`DCM_BIT_COMPE] && addr_hit)
    begin
      if (regs_reg.ctl[`DCM_BIT_INST])
        match_next = mon.inst;
      else
        match_next = !mon.inst && rw_hit && data_hit;
    end
  end

  // Match output register
  always_ff @(posedge mclk)
  begin
    if (reset)
      match_reg <= 1'b0;
    else
      match_reg <= match_next;
  end

  // Checks on register access and matching
  default clocking dcm_cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  a_wr_blocked_armed: assert property (
    reg_wr && unit_armed |=> regs_reg == $past(regs_reg))
    else $error("write landed while armed");

  a_wr_blocked_trace: assert property (
    reg_wr && trace_in_progress_flag |=> regs_reg == $past(regs_reg))
    else $error("write landed while trace runs");

  a_data_top_read: assert property (
    reg_rd && reg_addr == `DCM_OFF_DATA && !reg_wr
    |=> reg_rdata == $past(regs_reg.data[31:24]))
    else $error("top data byte read wrong");

  a_data_low_write: assert property (
    wr_ok && reg_addr == `DCM_OFF_DATA_END
    |=> regs_reg.data[7:0] == $past(reg_wdata))
    else $error("bottom data byte not written");

  a_mask_top_write: assert property (
    wr_ok && reg_addr == `DCM_OFF_MASK |=> regs_reg.mask[31:24] == $past(reg_wdata))
    else $error("top mask byte not written");

  a_addr_hi_write: assert property (
    wr_ok && reg_addr == `DCM_OFF_ADDR_HI |=> regs_reg.addr[23:16] == $past(reg_wdata))
    else $error("high address byte not written");

  a_addr_miss: assert property (
    mon.valid && mon.addr != regs_reg.addr |=> !comp_match)
    else $error("match without address hit");

  a_data_mismatch: assert property (
    mon.valid && !mon.cop && !regs_reg.ctl[`DCM_BIT_INST] && !regs_reg.ctl[`DCM_BIT_NDB]
    && !data_equal(mon.data, regs_reg.data, regs_reg.mask) |=> !comp_match)
    else $error("match on differing unmasked data");

  a_cop_low_half: assert property (
    mon.valid && mon.cop && !mon.inst && addr_hit && regs_reg.ctl == 8'h01
    && data_equal(mon.data, regs_reg.data, {16'h0000, regs_reg.mask[15:0]})
    |=> comp_match)
    else $error("coprocessor low half compare missed");

  a_invert_data: assert property (
    mon.valid && !mon.cop && regs_reg.ctl[`DCM_BIT_NDB] && !regs_reg.ctl[`DCM_BIT_INST]
    && data_equal(mon.data, regs_reg.data, regs_reg.mask) |=> !comp_match)
    else $error("inverted compare matched equal data");

  a_data_reset_zero: assert property (
    $fell(reset) |-> regs_reg.data == 32'h00000000 && reg_rdata == 8'h00)
    else $error("data value not zero after reset");

  a_rdata_one_cycle: assert property (
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside its cycle");

  // Further byte lanes: middle and low address, the end lanes of data and mask
  a_addr_mid_write: assert property (
    wr_ok && reg_addr == `DCM_OFF_ADDR_MID |=> regs_reg.addr[15:8] == $past(reg_wdata))
    else $error("middle address byte not written");

  a_addr_lo_write: assert property (
    wr_ok && reg_addr == `DCM_OFF_ADDR_LO |=> regs_reg.addr[7:0] == $past(reg_wdata))
    else $error("low address byte not written");

  a_mask_low_write: assert property (
    wr_ok && reg_addr == `DCM_OFF_MASK_END |=> regs_reg.mask[7:0] == $past(reg_wdata))
    else $error("bottom mask byte not written");

  a_mask_top_read: assert property (
    reg_rd && reg_addr == `DCM_OFF_MASK |=> reg_rdata == $past(regs_reg.mask[31:24]))
    else $error("top mask byte read wrong");

  a_data_low_read: assert property (
    reg_rd && reg_addr == `DCM_OFF_DATA_END |=> reg_rdata == $past(regs_reg.data[7:0]))
    else $error("bottom data byte read wrong");

  a_addr_lo_read: assert property (
    reg_rd && reg_addr == `DCM_OFF_ADDR_LO |=> reg_rdata == $past(regs_reg.addr[7:0]))
    else $error("low address byte read wrong");

  // Coprocessor low half, cleared mask, enable, idle bus, instruction mode and direction
  a_cop_low_miss: assert property (
    mon.valid && mon.cop && regs_reg.ctl == 8'h01
    && !data_equal(mon.data, regs_reg.data, {16'h0000, regs_reg.mask[15:0]})
    |=> !comp_match)
    else $error("coprocessor matched on differing low half");

  a_mask_clear_free: assert property (
    mon.valid && !mon.inst && addr_hit && regs_reg.ctl == 8'h01
    && regs_reg.mask == 32'h00000000 |=> comp_match)
    else $error("cleared mask still compared data");

  a_enable_off: assert property (
    !regs_reg.ctl[`DCM_BIT_COMPE] |=> !comp_match)
    else $error("match while comparator disabled");

  a_idle_no_match: assert property (
    !mon.valid |=> !comp_match)
    else $error("match without an access");

  a_inst_no_data: assert property (
    mon.valid && mon.inst && addr_hit && regs_reg.ctl[`DCM_BIT_INST]
    && regs_reg.ctl[`DCM_BIT_COMPE] |=> comp_match)
    else $error("instruction match missed");

  a_read_qualify: assert property (
    mon.valid && !mon.inst && regs_reg.ctl[`DCM_BIT_RWE] && !regs_reg.ctl[`DCM_BIT_INST]
    && mon.read != regs_reg.ctl[`DCM_BIT_RW] |=> !comp_match)
    else $error("match on wrong access direction");

  c_data_match: cover property (
    mon.valid && !regs_reg.ctl[`DCM_BIT_INST] ##1 comp_match);
  c_inst_match: cover property (
    mon.valid && mon.inst && regs_reg.ctl[`DCM_BIT_INST] ##1 comp_match);
  c_blocked_write: cover property (reg_wr && unit_armed);
  c_back_to_back: cover property (reg_wr ##1 reg_rd);

endmodule

// ### dv/dcm_bus_model.sv
// Model of the monitored processor and coprocessor bus
`timescale 1ns/1ps
module dcm_bus_model
(
  input wire logic mclk,
  input wire logic req,
  input wire dcm_pkg::dcm_access_t acc,
  output dcm_pkg::dcm_access_t mon
);
  dcm_pkg::dcm_access_t last = '0;
  initial mon = '0;
  // One access per request; an idle bus shows the inverse of the last access
  always @(posedge mclk)
  begin
    mon <= req ? acc : {1'b0, ~last[58:0]};
    if (req)
      last <= acc;
  end
endmodule

// ### dv/tb_top.sv
// Self-checking bench for the comparator C match registers
`timescale 1ns/1ps
`include "dcm_consts.svh"
module tb_top;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic unit_armed = 1'b0;
  logic trace_in_progress_flag = 1'b0;
  logic req = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic comp_match;
  dcm_pkg::dcm_access_t acc = '0;
  dcm_pkg::dcm_access_t mon;
  int num_errors = 0;
  int n_compared = 0;
  // Rows: byte address, byte
  logic [23:0] rows [11] = '{24'h013512, 24'h013634, 24'h013756, 24'h013811, 24'h013922,
    24'h013A33, 24'h013B44, 24'h013C00, 24'h013D00, 24'h013EFF, 24'h013FFF};
  // Rows: match expected, coprocessor, address, data
  logic [57:0] accs [6] = '{58'h2_123456_AAAA3344, 58'h0_123456_AAAA3345,
    58'h0_923456_AAAA3344, 58'h0_123457_AAAA3344, 58'h3_123456_FFFF3344,
    58'h1_123456_FFFF3340};

  dcm_match_regs i_dcm_match_regs
  (
    .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .unit_armed(unit_armed),
    .trace_in_progress_flag(trace_in_progress_flag), .mon(mon), .comp_match(comp_match)
  );
  dcm_bus_model i_dcm_bus_model
  (
    .mclk(mclk), .req(req), .acc(acc), .mon(mon)
  );

  // 25 MHz clock
  always #20 mclk = ~mclk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
  begin
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
  begin
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  end
  endtask

  // One-cycle read strobe, data looked at in the following cycle
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
  begin
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  end
  endtask

  // One bus access, match looked at one cycle after it is seen
  task automatic hit(input logic [57:0] r, input logic [1:0] ir = 2'b00);
  begin
    @(posedge mclk);
    req <= 1'b1;
    acc <= {1'b1, ir, r[56:0]};
    @(posedge mclk);
    req <= 1'b0;
    @(posedge mclk);
    #1 chk(comp_match, r[57]);
  end
  endtask

  task automatic end_of_test;
  begin
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask

  // Watchdog against a hang
  initial
  begin
    repeat (5000) @(posedge mclk);
    num_errors++;
    end_of_test();
  end

  // Main sequence
  initial
  begin
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    foreach (rows[i])
      rd(rows[i][23:8], 8'h00);
    foreach (rows[i])
      wr(rows[i][23:8], rows[i][7:0]);
    foreach (rows[i])
      rd(rows[i][23:8], rows[i][7:0]);
    // Unmapped place ignores writes and reads zero
    wr(16'h0134, 8'hAA);
    rd(16'h0134, 8'h00);
    // Writes blocked while armed or tracing
    @(posedge mclk) unit_armed <= 1'b1;
    wr(`DCM_OFF_DATA_END, 8'h00);
    rd(`DCM_OFF_DATA_END, 8'h44);
    @(posedge mclk) unit_armed <= 1'b0;
    trace_in_progress_flag <= 1'b1;
    wr(`DCM_OFF_MASK, 8'h5A);
    rd(`DCM_OFF_MASK, 8'h00);
    @(posedge mclk) trace_in_progress_flag <= 1'b0;
    // Disabled comparator never matches
    hit(58'h0_123456_AAAA3344);
    wr(`DCM_OFF_CTL, 8'h01);
    foreach (accs[i])
      hit(accs[i]);
    // Data invert: match on difference
    wr(`DCM_OFF_CTL, 8'h41);
    hit(58'h0_123456_AAAA3344);
    hit(58'h2_123456_AAAA3345);
    // Upper mask byte set: coprocessor ignores it, full width does not
    wr(`DCM_OFF_CTL, 8'h01);
    wr(`DCM_OFF_MASK, 8'hFF);
    hit(58'h3_123456_AAAA3344);
    hit(58'h0_123456_AAAA3344);
    hit(58'h2_123456_11AA3344);
    // Direction qualified on reads only
    wr(`DCM_OFF_CTL, 8'h0D);
    hit(58'h2_123456_11AA3344, 2'b01);
    hit(58'h0_123456_11AA3344, 2'b00);
    // Instruction mode ignores data and the invert bit
    wr(`DCM_OFF_CTL, 8'h61);
    hit(58'h2_123456_00000000, 2'b10);
    hit(58'h0_123456_11AA3344, 2'b00);
    // Write then read with no gap between strobes
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= `DCM_OFF_DATA_END;
    reg_wdata <= 8'h55;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, 8'h55);
    // Reset in mid-run clears every address, data and mask register
    @(posedge mclk) reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    foreach (rows[i])
      rd(rows[i][23:8], 8'h00);
    // Cleared mask leaves only the address to match
    for (int i = 0; i < 3; i++)
      wr(rows[i][23:8], rows[i][7:0]);
    wr(`DCM_OFF_CTL, 8'h01);
    hit(58'h2_123456_DEADBEEF);
    end_of_test();
  end
endmodule
